// ===== src/srce_pkg.sv
// Behaviour
// - Long read opcodes return 516 bytes
// - Long read: 256 words then 4 bytes
// - Long read never flags stored-check errors
// - Long read covers exactly one sector
// - Block count 1 minimum, larger allowed
// - Multiple read interrupts once per block
// - Data request qualifies only block start
// - Full blocks first, then remainder block
// - Abort multiple read without block count
// - Media error posted at block start
// - Continue only after correctable errors
// - Sector count zero means 256
// - Address from head, cylinders, sector
// - Busy, load, request, interrupt per sector
// - Success leaves last sector address
// - Failure stops at sector, keeps data
// - Verify: busy, no data, interrupt
// - Verify failure leaves unverified count
// - Opcodes 1Xh are no-operations
// - Request sense returns extended code
// - General extended error encodings
// - Media extended error encodings
package srce_pkg;
	// -------------------------------------------------
	// Register offsets
	// -------------------------------------------------
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_FEATURE = 3'h1;
	localparam logic [2:0] OFS_SECTOR_COUNT = 3'h2;
	localparam logic [2:0] OFS_SECTOR_NUMBER = 3'h3;
	localparam logic [2:0] OFS_CYLINDER_LOW = 3'h4;
	localparam logic [2:0] OFS_CYLINDER_HIGH = 3'h5;
	localparam logic [2:0] OFS_DRIVE_HEAD = 3'h6;
	localparam logic [2:0] OFS_COMMAND = 3'h7;
	localparam logic [3:0] OFS_BLOCK_COUNT = 4'h8;
	localparam logic [3:0] OFS_ERROR_CODE = 4'h9;
	// -------------------------------------------------
	// Status and head fields
	// -------------------------------------------------
	localparam int ST_BUSY = 7;
	localparam int ST_READY = 6;
	localparam int ST_DRQ = 3;
	localparam int ST_CORR = 2;
	localparam int ST_ERR = 0;
	localparam int DH_LBA = 6;
	localparam logic [7:0] ERR_ABORT_BIT = 8'h04;
	localparam logic [7:0] ERR_UNC_BIT = 8'h40;
	// -------------------------------------------------
	// Opcodes
	// -------------------------------------------------
	localparam logic [6:0] OP_READ = 7'h10;
	localparam logic [6:0] OP_LONG = 7'h11;
	localparam logic [6:0] OP_VERIFY = 7'h20;
	localparam logic [7:0] OP_MULTI = 8'hc4;
	localparam logic [7:0] OP_SENSE = 8'h03;
	localparam logic [3:0] OP_RECAL_HI = 4'h1;
	// -------------------------------------------------
	// Extended error codes
	// -------------------------------------------------
	localparam logic [7:0] XE_NONE = 8'h00;
	localparam logic [7:0] XE_SELFTEST_OK = 8'h01;
	localparam logic [7:0] XE_MISC = 8'h09;
	localparam logic [7:0] XE_INVALID_CMD = 8'h20;
	localparam logic [7:0] XE_INVALID_ADDR = 8'h21;
	localparam logic [7:0] XE_ADDR_OVERFLOW = 8'h2f;
	localparam logic [7:0] XE_ABORTED = 8'h1f;
	localparam logic [7:0] XE_POWER1_OFF = 8'h22;
	localparam logic [7:0] XE_UNCORRECTABLE = 8'h11;
	localparam logic [7:0] XE_CORRECTED = 8'h18;
	localparam logic [7:0] XE_ID_NOT_FOUND = 8'h10;
	localparam logic [7:0] XE_SPARES_OUT = 8'h3a;
	localparam logic [7:0] XE_WRITE_FAIL = 8'h03;
	localparam logic [7:0] XE_BAD_FORMAT = 8'h0c;
	localparam logic [7:0] XE_VOLTAGE = 8'h35;
	// -------------------------------------------------
	// Transfer sizes and reset values
	// -------------------------------------------------
	localparam logic [8:0] SECTOR_WORDS = 9'h100;
	localparam logic [2:0] LONG_BYTES = 3'h4;
	localparam logic [7:0] BLOCK_COUNT_RESET = 8'h00;
	localparam logic [7:0] STATUS_IDLE = 8'h40;
	// Media result kinds from the flash back end
	localparam logic [1:0] MR_OK = 2'h0;
	localparam logic [1:0] MR_CORRECTED = 2'h1;
	localparam logic [1:0] MR_FATAL = 2'h2;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_FETCH = 3'b001,
		S_WAIT = 3'b010,
		S_XFER = 3'b011,
		S_LONG = 3'b100,
		S_DONE = 3'b101
	} srce_state_t;
endpackage : srce_pkg

// ===== src/srce_decode.sv
`timescale 1ns/1ps
module srce_decode
	import srce_pkg::*;
(
	// Task file fields
	input wire logic [7:0] opcode,
	input wire logic [7:0] drive_head,
	input wire logic [7:0] cyl_high,
	input wire logic [7:0] cyl_low,
	input wire logic [7:0] sec_num,
	input wire logic [7:0] sec_cnt,
	// Decoded command
	output logic is_read,
	output logic is_long,
	output logic is_multi,
	output logic is_verify,
	output logic is_recal,
	output logic is_sense,
	output logic [27:0] lba,
	output logic [8:0] count
);
	always_comb begin
		is_read = opcode[7:1] == OP_READ;
		is_long = opcode[7:1] == OP_LONG;
		is_multi = opcode == OP_MULTI;
		is_verify = opcode[7:1] == OP_VERIFY;
		is_recal = opcode[7:4] == OP_RECAL_HI;
		is_sense = opcode == OP_SENSE;
		lba = {drive_head[3:0], cyl_high, cyl_low, sec_num};
		count = (sec_cnt == 8'h00) ? SECTOR_WORDS : {1'b0, sec_cnt};
	end
endmodule : srce_decode

// ===== src/srce_block.sv
`timescale 1ns/1ps
module srce_block
	import srce_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sector progress
	input wire logic [8:0] left,
	input wire logic [8:0] bsize,
	input wire logic [8:0] in_block,
	// Block boundary
	output logic block_start,
	output logic [8:0] this_block
);
	// Next block is full, or holds the remainder when fewer left
	always_comb begin
		block_start = in_block == 9'h000;
		this_block = (left < bsize) ? left : bsize;
	end
endmodule : srce_block

// ===== src/srce_engine.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
module srce_engine
	import srce_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Media back end
	output logic media_req,
	output logic [27:0] media_lba,
	input wire logic media_ack,
	input wire logic [1:0] media_result,
	input wire logic [7:0] media_code,
	input wire logic [15:0] media_word,
	input wire logic [7:0] media_check_byte,
	// Host interrupt and status
	output logic host_irq,
	output logic busy_flag,
	output logic data_request_flag
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		srce_state_t st;
		logic [7:0] op;
		logic [7:0] feature;
		logic [7:0] sec_cnt;
		logic [7:0] sec_num;
		logic [7:0] cyl_low;
		logic [7:0] cyl_high;
		logic [7:0] drive_head;
		logic [7:0] status;
		logic [7:0] err;
		logic [7:0] xcode;
		logic [7:0] block_count;
		logic [8:0] left;
		logic [8:0] in_block;
		logic [8:0] words;
		logic [2:0] bytes;
		logic stop_after;
		logic [1:0] mode;
		logic irq;
		logic media_req;
		logic [15:0] rdata;
	} srce_regs_t;

	srce_regs_t r;
	srce_regs_t next_r;

	logic is_read, is_long, is_multi, is_verify, is_recal, is_sense;
	logic [27:0] lba;
	logic [8:0] count;
	logic block_start;
	logic [8:0] this_block;
	logic [27:0] lba_inc;
	logic [7:0] cnt_left;

	// Ack, result and code pass two flops; a third ack flop finds the rising edge
	logic ack_s1, ack_s2, ack_s3;
	logic [1:0] res_s1, res_s2;
	logic [7:0] code_s1, code_s2;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ack_s3 <= 1'b0;
			res_s1 <= 2'h0;
			res_s2 <= 2'h0;
			code_s1 <= 8'h00;
			code_s2 <= 8'h00;
		end else begin
			ack_s1 <= media_ack;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
			res_s1 <= media_result;
			res_s2 <= res_s1;
			code_s1 <= media_code;
			code_s2 <= code_s1;
		end
	end
	wire ack_rise = ack_s2 & ~ack_s3;

	srce_decode u_decode (
		.opcode(wdata[7:0]),
		.drive_head(r.drive_head),
		.cyl_high(r.cyl_high),
		.cyl_low(r.cyl_low),
		.sec_num(r.sec_num),
		.sec_cnt(r.sec_cnt),
		.is_read(is_read),
		.is_long(is_long),
		.is_multi(is_multi),
		.is_verify(is_verify),
		.is_recal(is_recal),
		.is_sense(is_sense),
		.lba(lba),
		.count(count)
	);

	srce_block u_block (
		.clk(clk),
		.rst(rst),
		.left(r.left),
		.bsize({1'b0, r.block_count}),
		.in_block(r.in_block),
		.block_start(block_start),
		.this_block(this_block)
	);

	assign lba_inc = lba + 28'h0000001;
	assign cnt_left = r.sec_cnt - 8'h01;

	// Mode: 0 sectors, 1 multiple, 2 verify, 3 long
	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.irq = 1'b0;
		next_r.rdata = 16'h0000;
		// Register reads; data reads drain the sector
		if (rd) begin
			case (addr)
				{1'b0, OFS_DATA}: begin
					next_r.rdata = (r.st == S_LONG) ?
						{8'h00, media_check_byte} : media_word;
				end
				{1'b0, OFS_FEATURE}: next_r.rdata = {8'h00, r.err};
				{1'b0, OFS_SECTOR_COUNT}: next_r.rdata = {8'h00, r.sec_cnt};
				{1'b0, OFS_SECTOR_NUMBER}: next_r.rdata = {8'h00, r.sec_num};
				{1'b0, OFS_CYLINDER_LOW}: next_r.rdata = {8'h00, r.cyl_low};
				{1'b0, OFS_CYLINDER_HIGH}: next_r.rdata = {8'h00, r.cyl_high};
				{1'b0, OFS_DRIVE_HEAD}: next_r.rdata = {8'h00, r.drive_head};
				{1'b0, OFS_COMMAND}: next_r.rdata = {8'h00, r.status};
				OFS_BLOCK_COUNT: next_r.rdata = {8'h00, r.block_count};
				OFS_ERROR_CODE: next_r.rdata = {8'h00, r.xcode};
				default: next_r.rdata = 16'h0000;
			endcase
		end
		// Task file writes are refused while busy
		if (wr && !r.status[ST_BUSY]) begin
			case (addr)
				{1'b0, OFS_FEATURE}: next_r.feature = wdata[7:0];
				{1'b0, OFS_SECTOR_COUNT}: next_r.sec_cnt = wdata[7:0];
				{1'b0, OFS_SECTOR_NUMBER}: next_r.sec_num = wdata[7:0];
				{1'b0, OFS_CYLINDER_LOW}: next_r.cyl_low = wdata[7:0];
				{1'b0, OFS_CYLINDER_HIGH}: next_r.cyl_high = wdata[7:0];
				{1'b0, OFS_DRIVE_HEAD}: next_r.drive_head = wdata[7:0];
				OFS_BLOCK_COUNT: next_r.block_count = wdata[7:0];
				default: ;
			endcase
		end
		case (r.st)
			S_IDLE: begin
				if (wr && addr == {1'b0, OFS_COMMAND} && !r.status[ST_BUSY]) begin
					next_r.op = wdata[7:0];
					next_r.err = 8'h00;
					next_r.status = STATUS_IDLE;
					next_r.left = count;
					next_r.in_block = 9'h000;
					next_r.stop_after = 1'b0;
					if (is_read || is_long || is_multi || is_verify) begin
						next_r.status[ST_BUSY] = 1'b1;
						next_r.st = S_FETCH;
						next_r.xcode = XE_NONE;
						next_r.mode = is_multi ? 2'h1 : is_verify ? 2'h2 :
							is_long ? 2'h3 : 2'h0;
						if (is_long) begin
							next_r.left = 9'h001;
						end
						if (is_multi && r.block_count == BLOCK_COUNT_RESET) begin
							next_r.st = S_IDLE;
							next_r.status[ST_BUSY] = 1'b0;
							next_r.status[ST_ERR] = 1'b1;
							next_r.err = ERR_ABORT_BIT;
							next_r.xcode = XE_ABORTED;
							next_r.irq = 1'b1;
						end
					end else if (is_recal) begin
						next_r.xcode = XE_NONE;
						next_r.irq = 1'b1;
					end else if (is_sense) begin
						next_r.err = r.xcode;
						next_r.irq = 1'b1;
					end else begin
						next_r.status[ST_ERR] = 1'b1;
						next_r.err = ERR_ABORT_BIT;
						next_r.xcode = XE_INVALID_CMD;
						next_r.irq = 1'b1;
					end
				end
			end
			S_FETCH: begin
				next_r.media_req = 1'b1;
				next_r.st = S_WAIT;
			end
			S_WAIT: begin
				if (ack_rise) begin
					next_r.media_req = 1'b0;
					next_r.status[ST_BUSY] = 1'b0;
					// Long reads skip the stored check bytes
					if (r.mode != 2'h3 && res_s2 != MR_OK) begin
						next_r.xcode = code_s2;
						if (res_s2 == MR_CORRECTED) begin
							next_r.status[ST_CORR] = 1'b1;
						end else begin
							next_r.status[ST_ERR] = 1'b1;
							next_r.err = ERR_UNC_BIT;
							next_r.stop_after = 1'b1;
						end
					end
					if (r.mode == 2'h2) begin
						// Verify moves no data
						next_r.left = r.left - 9'h001;
						if (res_s2 == MR_FATAL || r.left == 9'h001) begin
							next_r.st = S_DONE;
							next_r.irq = 1'b1;
						end else begin
							next_r.st = S_FETCH;
							next_r.status[ST_BUSY] = 1'b1;
						end
						if (res_s2 != MR_FATAL) begin
							next_r.sec_cnt = cnt_left;
							if (r.left != 9'h001) begin
								{next_r.drive_head[3:0], next_r.cyl_high,
									next_r.cyl_low, next_r.sec_num} = lba_inc;
							end
						end
					end else begin
						next_r.status[ST_DRQ] = 1'b1;
						next_r.st = S_XFER;
						next_r.words = SECTOR_WORDS;
						if (r.mode != 2'h1 || block_start) begin
							next_r.irq = 1'b1;
						end
						if (r.mode == 2'h1 && block_start) begin
							next_r.in_block = this_block;
						end
					end
				end
			end
			S_XFER: begin
				if (rd && addr == {1'b0, OFS_DATA}) begin
					next_r.words = r.words - 9'h001;
					if (r.words == 9'h001) begin
						next_r.left = r.left - 9'h001;
						if (r.mode == 2'h1) begin
							next_r.in_block = r.in_block - 9'h001;
						end
						if (r.mode == 2'h3) begin
							next_r.st = S_LONG;
							next_r.bytes = LONG_BYTES;
						end else if (r.left == 9'h001 ||
							(r.stop_after && (r.mode != 2'h1 ||
							r.in_block == 9'h001))) begin
							next_r.st = S_DONE;
							next_r.status[ST_DRQ] = 1'b0;
						end else begin
							next_r.status[ST_DRQ] = r.mode == 2'h1 &&
								r.in_block != 9'h001;
							next_r.status[ST_BUSY] = ~next_r.status[ST_DRQ];
							next_r.st = next_r.status[ST_DRQ] ? S_XFER : S_FETCH;
							next_r.words = SECTOR_WORDS;
							next_r.sec_cnt = cnt_left;
							{next_r.drive_head[3:0], next_r.cyl_high,
								next_r.cyl_low, next_r.sec_num} = lba_inc;
						end
					end
				end
			end
			S_LONG: begin
				if (rd && addr == {1'b0, OFS_DATA}) begin
					next_r.bytes = r.bytes - 3'h1;
					if (r.bytes == 3'h1) begin
						next_r.st = S_DONE;
						next_r.status[ST_DRQ] = 1'b0;
					end
				end
			end
			S_DONE: next_r.st = S_IDLE;
			default: next_r.st = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.status <= STATUS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign rdata = r.rdata;
	assign host_irq = r.irq;
	assign busy_flag = r.status[ST_BUSY];
	assign data_request_flag = r.status[ST_DRQ];
	assign media_req = r.media_req;
	assign media_lba = {r.drive_head[3:0], r.cyl_high, r.cyl_low, r.sec_num};

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_busy_drq_excl: assert property (!(busy_flag && data_request_flag))
		else $error("busy and data request together");
	a_verify_no_drq: assert property (r.mode == 2'h2 && r.st != S_IDLE
		|-> !data_request_flag) else $error("verify raised drq");
	a_multi_abort: assert property (wr && addr == {1'b0, OFS_COMMAND}
		&& wdata[7:0] == OP_MULTI && r.st == S_IDLE && !busy_flag
		&& r.block_count == 8'h00 |=> host_irq && r.err == ERR_ABORT_BIT)
		else $error("multi without count not aborted");
	a_bad_opcode: assert property (wr && addr == {1'b0, OFS_COMMAND}
		&& wdata[7:0] == 8'hff && r.st == S_IDLE && !busy_flag
		|=> r.xcode == XE_INVALID_CMD) else $error("bad opcode");
	a_sense_copy: assert property (wr && addr == {1'b0, OFS_COMMAND}
		&& wdata[7:0] == OP_SENSE && r.st == S_IDLE && !busy_flag
		|=> r.err == $past(r.xcode)) else $error("sense code lost");
	a_long_no_err: assert property (r.mode == 2'h3 && r.st != S_IDLE
		|-> !r.status[ST_ERR]) else $error("long read error");
	a_long_bytes: assert property (r.st == S_LONG |-> r.bytes <= 3'h4)
		else $error("long tail over four bytes");
	a_drq_irq: assert property ($rose(data_request_flag) && r.mode == 2'h0
		|-> host_irq) else $error("sector without interrupt");
	c_read_done: cover property (r.st == S_XFER ##[1:600] r.st == S_DONE);
	c_long_tail: cover property (r.st == S_LONG);
	c_verify: cover property (r.mode == 2'h2 && r.st == S_DONE);
	c_abort: cover property (r.xcode == XE_INVALID_CMD);
	c_multi_block: cover property (r.mode == 2'h1 && r.st == S_WAIT
		&& ack_rise && block_start);
endmodule : srce_engine

// ===== bench/srce_media_model.sv
`timescale 1ns/1ps
module srce_media_model
	import srce_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Request from the engine
	input wire logic media_req,
	input wire logic [27:0] media_lba,
	// Fault injection from the bench
	input wire logic [27:0] bad_lba,
	input wire logic [1:0] bad_kind,
	// Answer to the engine
	output logic media_ack,
	output logic [1:0] media_result,
	output logic [7:0] media_code,
	output logic [15:0] media_word,
	output logic [7:0] media_check_byte
);
	logic [2:0] wait_cnt;
	logic hit;

	assign hit = (media_lba === bad_lba);
	// Slow answer so the busy phase of every fetch is visible
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_cnt <= 3'h0;
			media_ack <= 1'b0;
		end else if (!media_req) begin
			wait_cnt <= 3'h0;
			media_ack <= 1'b0;
		end else if (wait_cnt != 3'h4) begin
			wait_cnt <= wait_cnt + 3'h1;
		end else begin
			media_ack <= 1'b1;
		end
	end
	assign media_result = hit ? bad_kind : MR_OK;
	assign media_code = !hit ? XE_NONE :
		(bad_kind == MR_FATAL) ? XE_UNCORRECTABLE : XE_CORRECTED;
	// Sector content follows the address so misplaced data shows
	assign media_word = media_lba[15:0] ^ 16'h5a5a;
	assign media_check_byte = media_lba[7:0] ^ 8'hc3;
endmodule : srce_media_model

// ===== bench/storage_card_read_command_engine_tb.sv
`timescale 1ns/1ps
module storage_card_read_command_engine_tb
	import srce_pkg::*;
;
	logic clk, rst, wr, rd, media_req, media_ack, host_irq;
	logic busy_flag, data_request_flag;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, media_word, d;
	logic [27:0] media_lba, bad_lba;
	logic [1:0] media_result, bad_kind;
	logic [7:0] media_code, media_check_byte;
	int n_fail, check_count, irq_n, drq_n, n0, i, k;

	srce_engine dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .media_req(media_req),
		.media_lba(media_lba), .media_ack(media_ack),
		.media_result(media_result), .media_code(media_code),
		.media_word(media_word), .media_check_byte(media_check_byte),
		.host_irq(host_irq), .busy_flag(busy_flag),
		.data_request_flag(data_request_flag));
	srce_media_model media (.clk(clk), .rst(rst), .media_req(media_req),
		.media_lba(media_lba), .bad_lba(bad_lba), .bad_kind(bad_kind),
		.media_ack(media_ack), .media_result(media_result),
		.media_code(media_code), .media_word(media_word),
		.media_check_byte(media_check_byte));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (host_irq === 1'b1) irq_n++;
		if (data_request_flag === 1'b1) drq_n++;
	end

	// -------------------------------------------------
	// Host access tasks
	// -------------------------------------------------
	task automatic chk(input logic [31:0] got, exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= {8'h00, v};
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wreg
	task automatic rreg(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rreg
	task automatic setup(input logic [27:0] lba, input logic [7:0] cnt);
		wreg(4'h2, cnt);
		wreg(4'h3, lba[7:0]);
		wreg(4'h4, lba[15:8]);
		wreg(4'h5, lba[23:16]);
		wreg(4'h6, {4'he, lba[27:24]});
	endtask : setup
	// A missing interrupt is a failure, never a hang
	task automatic wait_irq();
		int n;
		for (n = 0; n < 5000 && host_irq !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(32'(host_irq), 32'h1, "interrupt");
		// Let the closing edge pass so the pulse counter has seen it
		@(posedge clk);
		#1;
	endtask : wait_irq
	task automatic rsec(input logic [27:0] lba);
		for (int w = 0; w < 256; w++) begin
			rreg(OFS_DATA, d);
			chk(32'(d), 32'(lba[15:0] ^ 16'h5a5a), "word");
		end
	endtask : rsec
	task automatic status_bit(input int b, input logic v);
		rreg(4'h7, d);
		chk(32'(d[b]), 32'(v), "status bit");
	endtask : status_bit
	task automatic finish_test();
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	initial begin
		// Over four times the length of a clean run
		#200000;
		n_fail++;
		$display("BAD %0t timeout", $time);
		finish_test();
	end

	// -------------------------------------------------
	// Scenarios
	// -------------------------------------------------
	initial begin
		rst = 1'b1;
		{addr, wdata, wr, rd} = '0;
		bad_lba = 28'hfffffff;
		bad_kind = MR_OK;
		n_fail = 0;
		check_count = 0;
		irq_n = 0;
		drq_n = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rreg(4'h7, d);
		chk(32'(d), 32'(STATUS_IDLE), "idle status");
		// Two plain sectors, address split over four registers
		setup(28'h1234567, 8'h02);
		wreg(OFS_COMMAND, 8'h20);
		for (i = 0; i < 2; i++) begin
			wait_irq();
			chk(32'(media_lba), 32'h1234567 + i, "lba");
			chk({busy_flag, data_request_flag}, 32'h1, "flags");
			chk(32'(media_req), 32'h0, "fetch released");
			rsec(28'h1234567 + i);
		end
		rreg(4'h3, d);
		chk(32'(d[7:0]), 32'h68, "last sector");
		rreg(4'h4, d);
		chk(32'(d[7:0]), 32'h45, "last cyl low");
		// Long read over a broken sector: check bytes skipped
		bad_lba <= 28'h100;
		bad_kind <= MR_FATAL;
		setup(28'h100, 8'h01);
		wreg(OFS_COMMAND, 8'h23);
		wait_irq();
		rsec(28'h100);
		for (i = 0; i < 4; i++) begin
			rreg(OFS_DATA, d);
			chk(32'(d[7:0]), 32'h0c3, "check byte");
		end
		status_bit(ST_ERR, 1'b0);
		// Multiple read before any block count is set
		setup(28'h200, 8'h03);
		wreg(OFS_COMMAND, OP_MULTI);
		wait_irq();
		rreg(4'h1, d);
		chk(32'(d[7:0]), 32'(ERR_ABORT_BIT), "no block count");
		// Blocks of two over three sectors: full block, then one
		wreg(OFS_BLOCK_COUNT, 8'h02);
		setup(28'h200, 8'h03);
		wreg(OFS_COMMAND, OP_MULTI);
		wait_irq();
		n0 = irq_n;
		rsec(28'h200);
		chk(32'(data_request_flag), 32'h1, "drq in block");
		rsec(28'h201);
		wait_irq();
		chk(irq_n - n0, 32'h1, "one irq per block");
		rsec(28'h202);
		repeat (60) @(posedge clk);
		chk(irq_n - n0, 32'h1, "partial block last");
		// Error in first block: corrected goes on, fatal stops
		for (k = 1; k < 3; k++) begin
			bad_lba <= 28'h300;
			bad_kind <= k[1:0];
			setup(28'h300, 8'h04);
			wreg(OFS_COMMAND, OP_MULTI);
			wait_irq();
			status_bit(ST_ERR, k == 2);
			chk(32'(data_request_flag), 32'h1, "drq with error");
			n0 = irq_n;
			rsec(28'h300);
			rsec(28'h301);
			repeat (60) @(posedge clk);
			chk(irq_n - n0, 32'(k == 1), "next block");
			if (k == 1) rsec(28'h302);
			if (k == 1) rsec(28'h303);
		end
		// Verify 256 sectors (count 0), last one broken
		bad_lba <= 28'h5ff;
		bad_kind <= MR_FATAL;
		setup(28'h500, 8'h00);
		n0 = drq_n;
		wreg(OFS_COMMAND, 8'h40);
		chk(32'(busy_flag), 32'h1, "verify busy");
		wait_irq();
		chk(drq_n - n0, 32'h0, "verify no drq");
		rreg(4'h2, d);
		chk(32'(d[7:0]), 32'h1, "unverified");
		rreg(4'h3, d);
		chk(32'(d[7:0]), 32'hff, "failing sector");
		wreg(OFS_COMMAND, OP_SENSE);
		wait_irq();
		rreg(4'h1, d);
		chk(32'(d[7:0]), 32'(XE_UNCORRECTABLE), "sense media");
		// Clean verify, then every recalibrate opcode
		setup(28'h600, 8'h01);
		wreg(OFS_COMMAND, 8'h41);
		wait_irq();
		chk(32'(busy_flag), 32'h0, "verify done");
		for (i = 0; i < 16; i++) begin
			wreg(OFS_COMMAND, {4'h1, i[3:0]});
			wait_irq();
			status_bit(ST_ERR, 1'b0);
		end
		// Unknown opcode, then the sense code it leaves
		wreg(OFS_COMMAND, 8'h55);
		wait_irq();
		rreg(4'h1, d);
		chk(32'(d[7:0]), 32'(ERR_ABORT_BIT), "unknown op");
		wreg(OFS_COMMAND, OP_SENSE);
		wait_irq();
		rreg(4'h1, d);
		chk(32'(d[7:0]), 32'h20, "sense invalid");
		wreg(OFS_COMMAND, 8'hff);
		wait_irq();
		rreg(OFS_ERROR_CODE, d);
		chk(32'(d[7:0]), 32'h20, "code of ff");
		finish_test();
	end
endmodule : storage_card_read_command_engine_tb
